/* File: pkg/ahp_pkg.sv */
/*
 Constants, field positions and carrier types for the parallel host port,
 configuration word, status word and three word queues.
 Assumes a single system clock; host pins are synchronised inside the port.
*/
package ahp_pkg;
   // ****************************************
   // Widths and depths
   // ****************************************
   localparam int CR_W = 16;
   localparam int SR_W = 9;
   localparam int WORD_W = 32;
   localparam int HALF_W = 16;
   localparam int FIFO_DEPTH = 32;
   localparam int HALF_LEVEL = 16;
   localparam int LABELS = 16;
   localparam int LABEL_W = 8;
   // ****************************************
   // Configuration word fields
   // ****************************************
   localparam int CR_RX1_RATE = 0;
   localparam int CR_LABEL_MEM = 1;
   localparam int CR_LBL_EN1 = 2;
   localparam int CR_LBL_EN2 = 3;
   localparam int CR_PAR_EN = 4;
   localparam int CR_LOOP_N = 5;
   localparam int CR_DEC1_EN = 6;
   localparam int CR_DEC1_B9 = 7;
   localparam int CR_DEC1_B10 = 8;
   localparam int CR_DEC2_EN = 9;
   localparam int CR_DEC2_B9 = 10;
   localparam int CR_DEC2_B10 = 11;
   localparam int CR_PAR_POL = 12;
   localparam int CR_TX_RATE = 13;
   localparam int CR_RX2_RATE = 14;
   localparam int CR_BIT_ORDER = 15;
   localparam logic [15:0] CR_RESET = 16'h0000;
   // ****************************************
   // Status word fields
   // ****************************************
   localparam int SR_RX1_READY = 0;
   localparam int SR_RX1_HALF = 1;
   localparam int SR_RX1_FULL = 2;
   localparam int SR_RX2_READY = 3;
   localparam int SR_RX2_HALF = 4;
   localparam int SR_RX2_FULL = 5;
   localparam int SR_TX_EMPTY = 6;
   localparam int SR_TX_FULL = 7;
   localparam int SR_TX_HALF = 8;
   // ****************************************
   // Timing
   // ****************************************
   localparam int SYS_CLK_HZ = 50_000_000;
   localparam int MASTER_CLK_HZ = 1_000_000;
   localparam int MCLK_DIV = SYS_CLK_HZ / MASTER_CLK_HZ;
   localparam int RATE_FAST_DIV = 10;
   localparam int RATE_SLOW_DIV = 80;
   localparam int GAP_BITS = 4;
   // ****************************************
   // Types
   // ****************************************
   typedef struct packed {
      logic cws_n;
      logic rsr_n;
      logic en1_n;
      logic en2_n;
      logic pl1_n;
      logic pl2_n;
      logic sel;
      logic transmit_enable_in;
   } ahp_pins_t;
   typedef enum logic [1:0] {
      TX_IDLE = 2'b00,
      TX_MARK = 2'b01,
      TX_NULL = 2'b11,
      TX_GAP = 2'b10
   } ahp_tx_state_t;
endpackage

/* File: verilog/ahp_port.sv */
/*
 Host parallel port of a two-receiver, one-transmitter serial word device:
 configuration word, status word, label memories, three word queues and a
 simple transmit serialiser. Assumes the line receivers hand in checked
 32-bit words on the system clock, and host pins arrive asynchronously.
*/
`timescale 1ns/100ps
module ahp_port
#(
   parameter int DEPTH = ahp_pkg::FIFO_DEPTH
)
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire logic clk_en,
   input wire ahp_pkg::ahp_pins_t host_pins,
   input wire logic [15:0] host_data_lines_in,
   output logic [15:0] host_data_lines_out,
   output logic host_data_lines_oe_n,
   input wire logic rx_one_word_valid,
   input wire logic [31:0] rx_one_word,
   input wire logic rx_two_word_valid,
   input wire logic [31:0] rx_two_word,
   output logic rx_one_data_ready_n,
   output logic rx_one_half_full_n,
   output logic rx_one_full_n,
   output logic rx_two_data_ready_n,
   output logic rx_two_half_full_n,
   output logic rx_two_full_n,
   output logic tx_queue_half_full_n,
   output logic tx_queue_full_n,
   output logic tx_ready,
   output logic tx_clk_out,
   output logic line_out_a,
   output logic line_out_b,
   output logic rx_one_rate_slow,
   output logic rx_two_rate_slow,
   output logic tx_slope_slow
);
   import ahp_pkg::*;

   // Pointers and memories are sized for this depth only
   if (DEPTH != FIFO_DEPTH)
   begin : g_depth_check
      $error("Queue depth must be 32");
   end

   // ****************************************
   // Helpers
   // ****************************************
   function automatic logic [15:0] word_to_half(input logic [31:0] w, input logic sel,
                                                input logic order);
      logic [15:0] h;
      h = '0;
      if (order)
         h = sel ? w[31:16] : w[15:0];
      else if (sel)
         h = w[28:13];
      else
      begin
         for (int i = 0; i < 8; i++)
            h[7 - i] = w[i];
         h[8] = w[31];
         h[9] = w[29];
         h[10] = w[30];
         h[15:11] = w[12:8];
      end
      return h;
   endfunction

   function automatic logic [31:0] halves_to_word(input logic [15:0] h1,
                                                  input logic [15:0] h2, input logic order);
      logic [31:0] w;
      w = {h2, h1};
      if (!order)
      begin
         for (int i = 0; i < 8; i++)
            w[i] = h1[7 - i];
         w[31] = h1[8];
         w[29] = h1[9];
         w[30] = h1[10];
         w[12:8] = h1[15:11];
         w[28:13] = h2;
      end
      return w;
   endfunction

   function automatic logic accept(input logic [31:0] w, input logic lbl_en,
                                   input logic [15:0][7:0] lbls, input logic dec_en,
                                   input logic b9, input logic b10);
      logic hit;
      hit = 1'b0;
      for (int i = 0; i < LABELS; i++)
         if (lbls[i] == w[7:0])
            hit = 1'b1;
      return (!lbl_en || hit) && (!dec_en || (w[8] == b9 && w[9] == b10));
   endfunction

   // ****************************************
   // Pin synchronisers and edges
   // ****************************************
   ahp_pins_t p1_q, p2_q, p3_q;
   logic [15:0] d1_q, d2_q;
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         p1_q <= '1;
         p2_q <= '1;
         p3_q <= '1;
         d1_q <= '0;
         d2_q <= '0;
      end
      else if (clk_en)
      begin
         p1_q <= host_pins;
         p2_q <= p1_q;
         p3_q <= p2_q;
         d1_q <= host_data_lines_in;
         d2_q <= d1_q;
      end
   end
   logic cws_fall, rsr_fall, pl1_fall, pl2_fall;
   logic [1:0] en_fall;
   assign cws_fall = p3_q.cws_n & ~p2_q.cws_n;
   assign rsr_fall = p3_q.rsr_n & ~p2_q.rsr_n;
   assign pl1_fall = p3_q.pl1_n & ~p2_q.pl1_n;
   assign pl2_fall = p3_q.pl2_n & ~p2_q.pl2_n;
   assign en_fall = {p3_q.en2_n & ~p2_q.en2_n, p3_q.en1_n & ~p2_q.en1_n};

   // ****************************************
   // Configuration word
   // ****************************************
   logic [15:0] cr_q;
   logic lbl_mode;
   assign lbl_mode = cr_q[CR_LABEL_MEM];
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         cr_q <= CR_RESET;
      else if (clk_en && cws_fall)
         cr_q <= d2_q;
   end
   assign rx_one_rate_slow = cr_q[CR_RX1_RATE];
   assign rx_two_rate_slow = cr_q[CR_RX2_RATE];
   assign tx_slope_slow = cr_q[CR_TX_RATE];

   // ****************************************
   // Label memories
   // ****************************************
   logic [1:0][15:0][7:0] lbl_q;
   logic [1:0][3:0] lbl_wp_q, lbl_rp_q;
   logic lbl_start;
   assign lbl_start = cws_fall && !lbl_mode && d2_q[CR_LABEL_MEM];
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         lbl_q <= '0;
         lbl_wp_q <= '0;
         lbl_rp_q <= '0;
      end
      else if (clk_en)
      begin
         if (lbl_start)
         begin
            lbl_wp_q <= '0;
            lbl_rp_q <= '0;
         end
         else if (lbl_mode)
         begin
            if (pl1_fall)
            begin
               lbl_q[0][lbl_wp_q[0]] <= d2_q[7:0];
               lbl_wp_q[0] <= lbl_wp_q[0] + 4'h1;
            end
            if (pl2_fall)
            begin
               lbl_q[1][lbl_wp_q[1]] <= d2_q[7:0];
               lbl_wp_q[1] <= lbl_wp_q[1] + 4'h1;
            end
            for (int r = 0; r < 2; r++)
               if (en_fall[r])
                  lbl_rp_q[r] <= lbl_rp_q[r] + 4'h1;
         end
      end
   end

   // ****************************************
   // Receive queues
   // ****************************************
   logic [31:0] rx_mem [2][32];
   logic [1:0][4:0] rx_wp_q, rx_rp_q;
   logic [1:0][5:0] rx_cnt_q;
   logic [1:0] rx_in_v, rx_ok, rx_pop;
   logic [1:0][31:0] rx_in_w;
   logic tx_done;
   logic [31:0] tx_shift_q;
   always_comb
   begin
      if (!cr_q[CR_LOOP_N])
      begin
         rx_in_v = {2{tx_done}};
         rx_in_w = {tx_shift_q, tx_shift_q};
      end
      else
      begin
         rx_in_v = {rx_two_word_valid, rx_one_word_valid};
         rx_in_w = {rx_two_word, rx_one_word};
      end
      rx_ok[0] = accept(rx_in_w[0], cr_q[CR_LBL_EN1], lbl_q[0], cr_q[CR_DEC1_EN],
                        cr_q[CR_DEC1_B9], cr_q[CR_DEC1_B10]);
      rx_ok[1] = accept(rx_in_w[1], cr_q[CR_LBL_EN2], lbl_q[1], cr_q[CR_DEC2_EN],
                        cr_q[CR_DEC2_B9], cr_q[CR_DEC2_B10]);
      rx_ok = rx_ok & rx_in_v & {2{!lbl_mode}};
      rx_pop = en_fall & {2{p2_q.sel && !lbl_mode}};
   end
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         rx_wp_q <= '0;
         rx_rp_q <= '0;
         rx_cnt_q <= '0;
      end
      else if (clk_en)
      begin
         for (int r = 0; r < 2; r++)
         begin
            logic pop, push, full;
            pop = rx_pop[r] && rx_cnt_q[r] != 6'h0;
            full = rx_cnt_q[r] == 6'(DEPTH);
            push = rx_ok[r] && (!full || pop);
            // Full queue: newest word overwrites the last slot
            if (rx_ok[r] && full && !pop)
               rx_mem[r][rx_wp_q[r] - 5'h1] <= rx_in_w[r];
            if (push)
            begin
               rx_mem[r][rx_wp_q[r]] <= rx_in_w[r];
               rx_wp_q[r] <= rx_wp_q[r] + 5'h1;
            end
            if (pop)
               rx_rp_q[r] <= rx_rp_q[r] + 5'h1;
            rx_cnt_q[r] <= rx_cnt_q[r] + 6'(push) - 6'(pop);
         end
      end
   end

   // ****************************************
   // Host read path
   // ****************************************
   logic [8:0] sr;
   logic [5:0] tx_cnt_q;
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         host_data_lines_out <= '0;
         host_data_lines_oe_n <= 1'b1;
      end
      else if (clk_en)
      begin
         host_data_lines_oe_n <= p2_q.rsr_n & p2_q.en1_n & p2_q.en2_n;
         if (rsr_fall)
            host_data_lines_out <= p2_q.sel ? cr_q : {7'h00, sr};
         else
            for (int r = 0; r < 2; r++)
               if (en_fall[r])
               begin
                  if (lbl_mode)
                     host_data_lines_out <= {8'h00, lbl_q[r][lbl_rp_q[r]]};
                  else
                     host_data_lines_out <= word_to_half(rx_mem[r][rx_rp_q[r]], p2_q.sel,
                                                         cr_q[CR_BIT_ORDER]);
               end
      end
   end

   // ****************************************
   // Status word and pins
   // ****************************************
   always_comb
   begin
      sr[SR_RX1_READY] = rx_cnt_q[0] != 6'h0;
      sr[SR_RX2_READY] = rx_cnt_q[1] != 6'h0;
      sr[SR_RX1_HALF] = rx_cnt_q[0] >= 6'(HALF_LEVEL);
      sr[SR_RX2_HALF] = rx_cnt_q[1] >= 6'(HALF_LEVEL);
      sr[SR_RX1_FULL] = rx_cnt_q[0] == 6'(DEPTH);
      sr[SR_RX2_FULL] = rx_cnt_q[1] == 6'(DEPTH);
      sr[SR_TX_EMPTY] = tx_cnt_q == 6'h0;
      sr[SR_TX_FULL] = tx_cnt_q == 6'(DEPTH);
      sr[SR_TX_HALF] = tx_cnt_q >= 6'(HALF_LEVEL);
   end
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         {rx_one_data_ready_n, rx_one_half_full_n, rx_one_full_n} <= '1;
         {rx_two_data_ready_n, rx_two_half_full_n, rx_two_full_n} <= '1;
         {tx_queue_full_n, tx_queue_half_full_n} <= '1;
      end
      else if (clk_en)
      begin
         rx_one_data_ready_n <= ~sr[SR_RX1_READY];
         rx_two_data_ready_n <= ~sr[SR_RX2_READY];
         rx_one_half_full_n <= ~sr[SR_RX1_HALF];
         rx_two_half_full_n <= ~sr[SR_RX2_HALF];
         rx_one_full_n <= ~sr[SR_RX1_FULL];
         rx_two_full_n <= ~sr[SR_RX2_FULL];
         tx_queue_full_n <= ~sr[SR_TX_FULL];
         tx_queue_half_full_n <= ~sr[SR_TX_HALF];
      end
   end

   // ****************************************
   // Transmit queue
   // ****************************************
   logic [31:0] tx_mem [32];
   logic [4:0] tx_wp_q, tx_rp_q;
   logic [15:0] half1_q;
   logic half1_v_q, tx_push, tx_pop;
   logic [31:0] tx_word;
   ahp_tx_state_t tx_st_q;
   logic mtick;
   always_comb
   begin
      tx_word = halves_to_word(half1_q, d2_q, cr_q[CR_BIT_ORDER]);
      if (cr_q[CR_PAR_EN])
         tx_word[31] = cr_q[CR_PAR_POL] ? ^tx_word[30:0] : ~^tx_word[30:0];
      tx_push = pl2_fall && half1_v_q && !lbl_mode && tx_cnt_q != 6'(DEPTH);
      tx_pop = mtick && tx_st_q == TX_IDLE && p2_q.transmit_enable_in && tx_cnt_q != 6'h0;
   end
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         half1_q <= '0;
         half1_v_q <= 1'b0;
         tx_wp_q <= '0;
         tx_rp_q <= '0;
         tx_cnt_q <= '0;
      end
      else if (clk_en)
      begin
         if (pl1_fall && !lbl_mode)
         begin
            half1_q <= d2_q;
            half1_v_q <= 1'b1;
         end
         else if (pl2_fall)
            half1_v_q <= 1'b0;
         if (tx_push)
         begin
            tx_mem[tx_wp_q] <= tx_word;
            tx_wp_q <= tx_wp_q + 5'h1;
         end
         if (tx_pop)
            tx_rp_q <= tx_rp_q + 5'h1;
         tx_cnt_q <= tx_cnt_q + 6'(tx_push) - 6'(tx_pop);
      end
   end

   // ****************************************
   // Serialiser and transmit clock
   // ****************************************
   logic [5:0] mdiv_q;
   logic [8:0] tick_q, tclk_q, half_ticks;
   logic [4:0] bit_q;
   assign mtick = mdiv_q == 6'(MCLK_DIV - 1);
   assign half_ticks = cr_q[CR_TX_RATE] ? 9'(RATE_SLOW_DIV / 2) : 9'(RATE_FAST_DIV / 2);
   assign tx_done = mtick && tx_st_q == TX_GAP && tick_q == 9'h0;
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         mdiv_q <= '0;
         tclk_q <= '0;
         tx_clk_out <= 1'b0;
      end
      else if (clk_en)
      begin
         mdiv_q <= mtick ? 6'h0 : mdiv_q + 6'h1;
         if (mtick)
         begin
            tclk_q <= (tclk_q >= half_ticks - 9'h1) ? 9'h0 : tclk_q + 9'h1;
            if (tclk_q >= half_ticks - 9'h1)
               tx_clk_out <= ~tx_clk_out;
         end
      end
   end
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_st_q <= TX_IDLE;
         tick_q <= '0;
         bit_q <= '0;
         tx_shift_q <= '0;
         {line_out_a, line_out_b} <= 2'b00;
      end
      else if (clk_en && mtick)
      begin
         unique case (tx_st_q)
            TX_IDLE:
               if (tx_pop)
               begin
                  tx_shift_q <= tx_mem[tx_rp_q];
                  tx_st_q <= TX_MARK;
                  tick_q <= half_ticks - 9'h1;
                  bit_q <= '0;
                  {line_out_a, line_out_b} <= tx_mem[tx_rp_q][0] ? 2'b10 : 2'b01;
               end
            TX_MARK:
               if (tick_q == 9'h0)
               begin
                  {line_out_a, line_out_b} <= 2'b00;
                  tx_st_q <= TX_NULL;
                  tick_q <= half_ticks - 9'h1;
               end
               else
                  tick_q <= tick_q - 9'h1;
            TX_NULL:
               if (tick_q != 9'h0)
                  tick_q <= tick_q - 9'h1;
               else if (bit_q == 5'd31)
               begin
                  tx_st_q <= TX_GAP;
                  tick_q <= 9'(half_ticks * 9'(2 * GAP_BITS)) - 9'h1;
               end
               else
               begin
                  bit_q <= bit_q + 5'h1;
                  tx_st_q <= TX_MARK;
                  tick_q <= half_ticks - 9'h1;
                  {line_out_a, line_out_b} <= tx_shift_q[bit_q + 5'h1] ? 2'b10 : 2'b01;
               end
            TX_GAP:
               if (tick_q == 9'h0)
                  tx_st_q <= TX_IDLE;
               else
                  tick_q <= tick_q - 9'h1;
         endcase
      end
   end

   // ****************************************
   // Transmit ready
   // ****************************************
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
         tx_ready <= 1'b1;
      else if (clk_en)
      begin
         // low on load, high when drained
         if (tx_push)
            tx_ready <= 1'b0;
         else if (tx_st_q == TX_IDLE && tx_cnt_q == 6'h0)
            tx_ready <= 1'b1;
      end
   end
endmodule

/* File: verification/ahp_port_monitor.sv */
/*
 Checker of the host port: bus drive timing, status pin order, transmit
 idle level, rate outputs and transmit clock activity.
 Assumes it is bound into ahp_port with clk_en held high.
*/
`timescale 1ns/100ps
module ahp_port_monitor
(
   input wire logic sys_clk,
   input wire logic rst_n,
   input wire ahp_pkg::ahp_pins_t host_pins,
   input wire logic host_data_lines_oe_n,
   input wire logic rx_one_data_ready_n,
   input wire logic rx_one_half_full_n,
   input wire logic rx_one_full_n,
   input wire logic tx_queue_half_full_n,
   input wire logic tx_queue_full_n,
   input wire logic tx_ready,
   input wire logic tx_clk_out,
   input wire logic line_out_a,
   input wire logic line_out_b,
   input wire logic rx_two_rate_slow,
   input wire logic tx_slope_slow
);
   import ahp_pkg::*;
   // ****
   // Helpers
   // ****
   logic rd_low;
   logic clk_q;
   logic [12:0] hold_q;
   assign rd_low = !(host_pins.rsr_n && host_pins.en1_n && host_pins.en2_n);
   // Slow half period is 2000 cycles; margin covers a rate change
   always_ff @(posedge sys_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         clk_q <= 1'b0;
         hold_q <= 13'h0000;
      end
      else
      begin
         clk_q <= tx_clk_out;
         hold_q <= (clk_q != tx_clk_out) ? 13'h0000 : hold_q + 13'h0001;
      end
   end
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rst_n);
   // ****
   // Properties
   // ****
   property p_oe_cause;
      $fell(host_data_lines_oe_n) |-> $past(rd_low, 2);
   endproperty
   a_oe_cause: assert property (p_oe_cause)
      else $error("bus driven without read");
   property p_oe_release;
      (!rd_low) [*8] |-> host_data_lines_oe_n;
   endproperty
   a_oe_release: assert property (p_oe_release)
      else $error("bus still driven");
   property p_rx_chain;
      !rx_one_full_n |-> !rx_one_half_full_n && !rx_one_data_ready_n;
   endproperty
   a_rx_chain: assert property (p_rx_chain)
      else $error("receive flags disagree");
   property p_tx_full;
      !tx_queue_full_n |-> !tx_queue_half_full_n;
   endproperty
   a_tx_full: assert property (p_tx_full)
      else $error("transmit flags disagree");
   property p_tx_half;
      !tx_queue_half_full_n |-> !tx_ready;
   endproperty
   a_tx_half: assert property (p_tx_half)
      else $error("ready with words queued");
   property p_ready_quiet;
      tx_ready |-> !line_out_a && !line_out_b;
   endproperty
   a_ready_quiet: assert property (p_ready_quiet)
      else $error("line active while ready");
   property p_rate_hold;
      host_pins.cws_n [*8] |-> $stable(tx_slope_slow) && $stable(rx_two_rate_slow);
   endproperty
   a_rate_hold: assert property (p_rate_hold)
      else $error("rate changed without write");
   property p_clk_alive;
      hold_q < 13'd4100;
   endproperty
   a_clk_alive: assert property (p_clk_alive)
      else $error("transmit clock stuck");
endmodule

bind ahp_port ahp_port_monitor u_mon
(
   .sys_clk, .rst_n, .host_pins, .host_data_lines_oe_n, .rx_one_data_ready_n,
   .rx_one_half_full_n, .rx_one_full_n, .tx_queue_half_full_n, .tx_queue_full_n,
   .tx_ready, .tx_clk_out, .line_out_a, .line_out_b, .rx_two_rate_slow, .tx_slope_slow
);

/* File: verification/ahp_host.sv */
/*
 Host processor model: strobed writes and reads on the shared 16-bit bus.
 Assumes the port samples its pins on sys_clk.
*/
`timescale 1ns/100ps
module ahp_host
(
   input wire logic sys_clk,
   input wire logic transmit_enable_in,
   input wire logic [15:0] dev_data,
   input wire logic dev_oe_n,
   output ahp_pkg::ahp_pins_t pins,
   output logic [15:0] bus
);
   import ahp_pkg::*;
   // ****
   // Bus and strobes
   // ****
   logic [5:0] stb_q = 6'h3f;
   logic sel_q = 1'b0;
   logic wr_q = 1'b0;
   logic tog_q = 1'b0;
   logic [15:0] drv_q = 16'h0000;
   // Undriven bus toggles so stale data never passes
   always @(posedge sys_clk)
      tog_q <= !tog_q;
   assign pins = {stb_q, sel_q, transmit_enable_in};
   assign bus = !dev_oe_n ? dev_data : wr_q ? drv_q : {16{tog_q}};
   task automatic xfer(input int i, input logic s, input logic [15:0] d,
                       output logic [15:0] q);
      @(posedge sys_clk);
      sel_q <= s;
      drv_q <= d;
      wr_q <= (i == 5 || i < 2);
      repeat (3) @(posedge sys_clk);
      stb_q[i] <= 1'b0;
      repeat (6) @(posedge sys_clk);
      q = bus;
      stb_q[i] <= 1'b1;
      repeat (4) @(posedge sys_clk);
      wr_q <= 1'b0;
   endtask
endmodule

/* File: verification/ahp_port_test.sv */
/*
 Self-checking bench of the host port: configuration, status, halves,
 decoder, labels, queue flags, loopback transmit and reset.
 Assumes the host model and checker are compiled before it.
*/
`timescale 1ns/100ps
`define CHK(n, e, a) \
   begin \
      samples_checked++; \
      if ((a) !== (e)) \
      begin \
         n_fail++; \
         $display("BAD %s exp %h got %h", n, e, a); \
      end \
   end
module ahp_port_test;
   import ahp_pkg::*;
   typedef struct packed {
      logic [15:0] cfg;
      logic [2:0] rates;
   } ahp_row_t;
   localparam int CW = 5;
   localparam int RS = 4;
   localparam int E1 = 3;
   localparam int E2 = 2;
   localparam logic [31:0] W2 = 32'hc3a51e69;
   localparam ahp_row_t ROWS [5] = '{'{16'h0001, 3'h1}, '{16'h4000, 3'h4},
      '{16'h2000, 3'h2}, '{16'hdead, 3'h5}, '{16'hffff, 3'h7}};
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic transmit_enable_in = 1'b0;
   logic rx_one_word_valid = 1'b0;
   logic rx_two_word_valid = 1'b0;
   logic [31:0] rx_word = 32'h0;
   ahp_pins_t host_pins;
   logic [15:0] host_data_lines_in, host_data_lines_out, q;
   logic host_data_lines_oe_n, rx_one_data_ready_n, rx_one_half_full_n, rx_one_full_n;
   logic rx_two_data_ready_n, rx_two_half_full_n, rx_two_full_n, tx_queue_half_full_n;
   logic tx_queue_full_n, tx_ready, tx_clk_out, line_out_a, line_out_b;
   logic rx_one_rate_slow, rx_two_rate_slow, tx_slope_slow;
   logic [8:0] flags;
   int n_fail = 0;
   int samples_checked = 0;
   always #10 sys_clk = !sys_clk;
   assign flags = {rx_one_data_ready_n, rx_one_half_full_n, rx_one_full_n,
      rx_two_data_ready_n, rx_two_half_full_n, rx_two_full_n,
      tx_queue_half_full_n, tx_queue_full_n, tx_ready};
   ahp_port dut
   (
      .sys_clk, .rst_n, .clk_en(1'b1), .host_pins, .host_data_lines_in,
      .host_data_lines_out, .host_data_lines_oe_n, .rx_one_word_valid,
      .rx_one_word(rx_word), .rx_two_word_valid, .rx_two_word(rx_word),
      .rx_one_data_ready_n, .rx_one_half_full_n, .rx_one_full_n, .rx_two_data_ready_n,
      .rx_two_half_full_n, .rx_two_full_n, .tx_queue_half_full_n, .tx_queue_full_n,
      .tx_ready, .tx_clk_out, .line_out_a, .line_out_b, .rx_one_rate_slow,
      .rx_two_rate_slow, .tx_slope_slow
   );
   ahp_host host
   (
      .sys_clk, .transmit_enable_in, .dev_data(host_data_lines_out), .dev_oe_n(host_data_lines_oe_n),
      .pins(host_pins), .bus(host_data_lines_in)
   );
   // ****
   // Tasks
   // ****
   function automatic logic [15:0] scr(input logic [31:0] w);
      logic [15:0] h;
      for (int i = 0; i < 8; i++)
         h[i] = w[7 - i];
      h[8] = w[31];
      h[9] = w[29];
      h[10] = w[30];
      h[15:11] = w[12:8];
      return h;
   endfunction
   task automatic rd(input int i, input logic s, input logic [15:0] e, input string n);
      host.xfer(i, s, 16'h0000, q);
      `CHK(n, e, q)
   endtask
   task automatic ld(input logic [31:0] w);
      host.xfer(1, 1'b0, w[15:0], q);
      host.xfer(0, 1'b1, w[31:16], q);
   endtask
   task automatic rxw(input logic two, input logic [31:0] w);
      @(posedge sys_clk);
      rx_word <= w;
      rx_one_word_valid <= !two;
      rx_two_word_valid <= two;
      @(posedge sys_clk);
      rx_one_word_valid <= 1'b0;
      rx_two_word_valid <= 1'b0;
      repeat (3) @(posedge sys_clk);
   endtask
   task automatic period(input int e);
      time t;
      @(posedge tx_clk_out);
      @(posedge tx_clk_out);
      t = $time;
      @(posedge tx_clk_out);
      `CHK("tx_clk", e, ($time - t) / 20)
   endtask
   task automatic conclude();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // ****
   // Tests
   // ****
   initial
   begin
      repeat (4) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      rd(RS, 1'b1, CR_RESET, "cfg");
      rd(RS, 1'b0, 16'h0040, "status");
      `CHK("flags", 9'h1ff, flags)
      period(MCLK_DIV * RATE_FAST_DIV);
      foreach (ROWS[i])
      begin
         host.xfer(CW, 1'b0, ROWS[i].cfg, q);
         rd(RS, 1'b1, ROWS[i].cfg, "cfg");
         `CHK("rates", ROWS[i].rates, {rx_two_rate_slow, tx_slope_slow, rx_one_rate_slow})
      end
      host.xfer(1, 1'b1, 16'h00a7, q);
      rd(E1, 1'b1, 16'h00a7, "label");
      period(MCLK_DIV * RATE_SLOW_DIV);
      $display("end rows");
      host.xfer(CW, 1'b0, 16'h8020, q);
      rxw(1'b0, 32'h1234abcd);
      `CHK("ready1", 1'b0, rx_one_data_ready_n)
      rd(E1, 1'b0, 16'habcd, "rx1 lo");
      rd(E1, 1'b1, 16'h1234, "rx1 hi");
      `CHK("ready1", 1'b1, rx_one_data_ready_n)
      host.xfer(CW, 1'b0, 16'h0020, q);
      rxw(1'b1, W2);
      rd(E2, 1'b0, scr(W2), "rx2 lo");
      rd(E2, 1'b1, W2[28:13], "rx2 hi");
      host.xfer(CW, 1'b0, 16'h8024, q);
      rxw(1'b0, 32'h000000a6);
      `CHK("label miss", 1'b1, rx_one_data_ready_n)
      host.xfer(CW, 1'b0, 16'h80e0, q);
      rxw(1'b0, 32'h0);
      `CHK("ready1", 1'b1, rx_one_data_ready_n)
      rxw(1'b0, 32'h00000100);
      rd(E1, 1'b0, 16'h0100, "dec lo");
      $display("end receive");
      host.xfer(CW, 1'b0, 16'h8020, q);
      repeat (32) rxw(1'b0, 32'h5555aaaa);
      repeat (33) ld(32'h1);
      rd(RS, 1'b0, 16'h0187, "status");
      `CHK("flags", 9'h038, flags)
      rd(E1, 1'b1, 16'h0000, "rx1 head");
      `CHK("full1", 1'b1, rx_one_full_n)
      rst_n <= 1'b0;
      repeat (2) @(posedge sys_clk);
      rst_n <= 1'b1;
      repeat (2) @(posedge sys_clk);
      `CHK("flags", 9'h1ff, flags)
      $display("end queues");
      host.xfer(CW, 1'b0, 16'h8010, q);
      ld(32'h3);
      `CHK("tx_ready", 1'b0, tx_ready)
      transmit_enable_in <= 1'b1;
      repeat (30000) if (tx_ready !== 1'b1) @(posedge sys_clk);
      `CHK("tx_ready", 1'b1, tx_ready)
      rd(E1, 1'b0, 16'h0003, "loop lo");
      rd(E1, 1'b1, 16'h8000, "loop hi");
      host.xfer(CW, 1'b0, 16'h9010, q);
      ld(32'h3);
      `CHK("tx_ready", 1'b0, tx_ready)
      repeat (30000) if (tx_ready !== 1'b1) @(posedge sys_clk);
      rd(E1, 1'b1, 16'h0000, "even hi");
      $display("end transmit");
      conclude();
   end
   initial
   begin
      repeat (90000) @(posedge sys_clk);
      n_fail++;
      conclude();
   end
endmodule
